// ===== hw/rej_timer_map.svh
// Purpose: Offsets, field positions, reset values and timing counts of the rejection timer.
// Assumes: APB byte addressing with one aligned 32-bit word per register.
// Notes: Definitions only.
`ifndef REJ_TIMER_MAP_SVH
`define REJ_TIMER_MAP_SVH
`define RT_CTRL_OFFSET 12'h710
`define RT_STAT_OFFSET 12'h714
`define RT_SPACING_LSB 0
`define RT_SPACING_W 14
`define RT_START_SEL_BIT 16
`define RT_SPACING_RST 14'h0947
`define RT_START_SEL_RST 1'h1
`define RT_TICK_NS 4
`define RT_CLK_NS 25
`endif

// ===== hw/rej_timer_pkg.sv
// Purpose: Types shared by the rejection timer files.
// Assumes: Nothing beyond SystemVerilog.
// Notes: Offsets and counts live in the map header.
package rej_timer_pkg;
  // APB request from the master.
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;
  // APB answer to the master.
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;
  // Timer states, one-hot.
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_WAIT = 3'h2,
    ST_COUNT = 3'h4
  } rt_state_t;
endpackage

// ===== hw/tick_divider.sv
// Purpose: Reports each cycle how many whole 4 ns ticks of the spacing count fell in the last clock.
// Assumes: The system clock is slower than the tick, so several ticks fall per cycle.
// Notes: A fractional accumulator gives an exact long-run tick rate.
`timescale 1ns/100ps
module tick_divider
  import rej_timer_pkg::*;
#(
  parameter int CLK_NS = 25,
  parameter int TICK_NS = 4
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic clear,
  output logic [7:0] ticks
);
  // Refuses ratios whose sum or remainder would not fit the 9-bit and 8-bit paths.
  if (TICK_NS < 1 || TICK_NS > 255 || CLK_NS < 1 || CLK_NS + TICK_NS > 511 || CLK_NS / TICK_NS > 200)
  begin : g_bad_ratio
    $error("tick_divider: unusable clock ratio");
  end
  // Remainder of tick time carried between cycles, in ns.
  logic [7:0] acc_q;
  logic [7:0] acc_d;
  logic [7:0] ticks_d;
  // Adds one clock period and splits it into whole ticks and a remainder.
  always_comb
  begin
    logic [8:0] sum;
    sum = 9'(acc_q) + 9'(CLK_NS);
    if (clear)
    begin
      sum = 9'(CLK_NS);
    end
    ticks_d = 8'(sum / 9'(TICK_NS));
    acc_d = 8'(sum % 9'(TICK_NS));
  end
  // Registers the remainder and the tick count.
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      acc_q <= 8'h00;
      ticks <= 8'h00;
    end
    else
    begin
      acc_q <= acc_d;
      ticks <= ticks_d;
    end
  end
endmodule

// ===== hw/l1_aspm_rejection_timer.sv
// Purpose: Holds off new L1 ASPM entry requests for a programmed time after a rejection.
// Assumes: Link events arrive as one-cycle pulses synchronous to mclk.
// Notes: The spacing count is in 4 ns units; several units may pass per 25 ns clock.
// Functional notes
// - Hold 14-bit programmable minimum request spacing.
// - Each unit is 4 ns; resets to 0x947.
// - Request is request DLLPs then acknowledge.
// - After rejection, wait before detecting requests.
// - Bit 16 start select; starts on Nak.
// - Select 0: early requests restart the timer.
// - Select 1: early requests are ignored.
// - After expiry, next request is new.
//
// Implementation choice: the APB slave port.
`timescale 1ns/100ps
`include "rej_timer_map.svh"
module l1_aspm_rejection_timer
  import rej_timer_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire apb_req_t apb_req,
  output apb_rsp_t apb_rsp,
  input wire logic req_dllp,
  input wire logic ack_sent,
  input wire logic nak_sent,
  output logic req_detect,
  output logic holdoff
);
  // Software spacing value in 4 ns units.
  logic [13:0] spacing_q;
  logic [13:0] spacing_d;
  // Start select: 0 restarts on early requests, 1 ignores them.
  logic start_sel_q;
  logic start_sel_d;
  // Read data register.
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  // Timer state and elapsed tick count.
  rt_state_t state_q;
  rt_state_t state_d;
  logic [14:0] count_q;
  logic [14:0] count_d;
  logic req_detect_d;
  // Ticks elapsed during the last clock.
  logic [7:0] ticks;
  logic tick_clear;

  // Returns the 32-bit control word as seen by software.
  function automatic logic [31:0] ctrl_word(input logic [13:0] sp, input logic sel);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`RT_SPACING_LSB +: `RT_SPACING_W] = sp;
    w[`RT_START_SEL_BIT] = sel;
    return w;
  endfunction

  // Returns true when the elapsed count has reached the spacing.
  function automatic logic reached(input logic [14:0] cnt, input logic [13:0] sp);
    return cnt >= {1'b0, sp};
  endfunction

  // Produces the per-cycle tick count of the 4 ns time base.
  // Several 4 ns units pass in each 25 ns clock, so the divider reports
  // how many whole units fell in the last cycle rather than a single pulse.
  tick_divider #(
    .CLK_NS(`RT_CLK_NS),
    .TICK_NS(`RT_TICK_NS)
  ) u_tick (
    .mclk(mclk),
    .rst(rst),
    .clear(tick_clear),
    .ticks(ticks)
  );

  // APB answers every access in its first access cycle.
  // No wait state is ever needed, since every register is a flip-flop.
  // Access phase of a transfer: select and enable both high.
  logic access;
  assign access = apb_req.psel && apb_req.penable;
  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = 1'b0;
  assign apb_rsp.prdata = rdata_q;

  // Register writes and read data selection.
  always_comb
  begin
    spacing_d = spacing_q;
    start_sel_d = start_sel_q;
    rdata_d = rdata_q;
    if (access && apb_req.pwrite && apb_req.paddr == `RT_CTRL_OFFSET)
    begin
      spacing_d = apb_req.pwdata[`RT_SPACING_LSB +: `RT_SPACING_W];
      start_sel_d = apb_req.pwdata[`RT_START_SEL_BIT];
    end
    // Read data is set up during the setup cycle so it is ready in the access cycle.
    // Reserved bits and unmapped offsets read as zero.
    if (apb_req.psel && !apb_req.penable)
    begin
      case (apb_req.paddr)
        `RT_CTRL_OFFSET:
        begin
          rdata_d = ctrl_word(spacing_q, start_sel_q);
        end
        `RT_STAT_OFFSET:
        begin
          rdata_d = {15'h0000, holdoff, 1'b0, count_q};
        end
        default:
        begin
          rdata_d = 32'h0000_0000;
        end
      endcase
    end
  end

  // Register storage.
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      spacing_q <= `RT_SPACING_RST;
      start_sel_q <= `RT_START_SEL_RST;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      // Writes land at the end of the access cycle.
      // programmable spacing
      spacing_q <= spacing_d;
      start_sel_q <= start_sel_d;
      rdata_q <= rdata_d;
    end
  end

  // Timer sequence: idle, request in progress, holdoff counting.
  always_comb
  begin
    // Elapsed units if the count advances; one bit wider to catch overflow.
    logic [15:0] next_cnt;
    next_cnt = 16'(count_q) + 16'(ticks);
    state_d = state_q;
    count_d = count_q;
    req_detect_d = 1'b0;
    tick_clear = 1'b0;
    case (state_q)
      ST_IDLE:
      begin
        // first request DLLP opens a request
        if (req_dllp)
        begin
          req_detect_d = 1'b1;
          state_d = ST_WAIT;
        end
      end
      ST_WAIT:
      begin
        // Further request DLLPs of the same request are absorbed here.
        // counting starts on Nak
        if (nak_sent)
        begin
          count_d = 15'h0000;
          tick_clear = 1'b1;
          state_d = (spacing_q == 14'h0000) ? ST_IDLE : ST_COUNT;
        end
        else if (ack_sent)
        begin
          state_d = ST_IDLE;
        end
      end
      ST_COUNT:
      begin
        // requests are not detected while counting
        if (reached(count_q, spacing_q))
        begin
          // a request at expiry is new
          state_d = ST_IDLE;
          if (req_dllp)
          begin
            req_detect_d = 1'b1;
            state_d = ST_WAIT;
          end
        end
        else if (req_dllp && !start_sel_q)
        begin
          count_d = 15'h0000;
          tick_clear = 1'b1;
        end
        // Otherwise the count advances and saturates rather than wrapping.
        // early request ignored
        else
        begin
          count_d = (next_cnt > 16'h7FFF) ? 15'h7FFF : next_cnt[14:0];
        end
      end
      default:
      begin
        // An illegal state code falls back to idle.
        state_d = ST_IDLE;
      end
    endcase
  end

  // Timer state registers.
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state_q <= ST_IDLE;
      count_q <= 15'h0000;
      req_detect <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      count_q <= count_d;
      req_detect <= req_detect_d;
    end
  end

  // Holdoff shows the timer is running.
  // It comes straight from the state register, so it carries no glitch from the link inputs.
  assign holdoff = (state_q == ST_COUNT);
endmodule

// ===== bench/rej_timer_chk.sv
// Purpose: Port assertions for the rejection timer.
// Assumes: The control word is tracked from APB writes.
// Notes: Hold lengths are judged in whole cycles.
`timescale 1ns/100ps
`include "rej_timer_map.svh"
module rej_timer_chk
  import rej_timer_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire apb_req_t apb_req,
  input wire apb_rsp_t apb_rsp,
  input wire logic req_dllp,
  input wire logic ack_sent,
  input wire logic nak_sent,
  input wire logic req_detect,
  input wire logic holdoff
);
  // Shadow spacing and select, open request flag, hold cycle count.
  logic [13:0] sp_q;
  logic sel_q;
  logic pend_q;
  int hc_q;
  int lim;
  assign lim = sp_q * `RT_TICK_NS / `RT_CLK_NS;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // The hold count restarts where a request may restart the timer.
  always_ff @(posedge mclk)
  begin
    if (rst)
      {sel_q, sp_q} <= {`RT_START_SEL_RST, `RT_SPACING_RST};
    else if (apb_req.psel && apb_req.penable && apb_req.pwrite && apb_req.paddr == `RT_CTRL_OFFSET)
      {sel_q, sp_q} <= {apb_req.pwdata[`RT_START_SEL_BIT], apb_req.pwdata[13:0]};
    pend_q <= !rst && (req_detect || (pend_q && !ack_sent && !nak_sent));
    hc_q <= (!holdoff || (req_dllp && !sel_q)) ? 0 : hc_q + 1;
  end
  // A Nak that closes an open request.
  sequence s_reject;
    nak_sent && pend_q;
  endsequence
  a_apb_answer: assert property (apb_req.psel |-> apb_rsp.pready && !apb_rsp.pslverr)
    else $error("bad APB answer");
  a_detect_cause: assert property (req_detect |-> $past(req_dllp))
    else $error("detect without request");
  a_detect_pulse: assert property (req_detect |=> !req_detect)
    else $error("detect too long");
  a_quiet_hold: assert property (holdoff |-> !req_detect)
    else $error("detect during hold");
  a_nak_hold: assert property (s_reject ##0 sp_q != 0 |=> holdoff)
    else $error("no hold after Nak");
  a_zero_space: assert property (s_reject ##0 sp_q == 0 |=> !holdoff)
    else $error("hold with zero spacing");
  a_hold_max: assert property (hc_q <= lim + 2)
    else $error("hold too long");
  a_hold_min: assert property ($fell(holdoff) |-> $past(hc_q) + 3 >= lim)
    else $error("hold too short");
  a_new_request: assert property (req_dllp && !holdoff && !pend_q && !req_detect |=> req_detect)
    else $error("request not detected while idle");
endmodule
bind l1_aspm_rejection_timer rej_timer_chk rej_timer_chk_inst (.mclk, .rst, .apb_req, .apb_rsp,
  .req_dllp, .ack_sent, .nak_sent, .req_detect, .holdoff);

// ===== bench/link_partner.sv
// Purpose: Link partner that sends L1 entry request DLLPs.
// Assumes: One DLLP is a one-cycle pulse.
// Notes: The gap sets how slowly a burst comes.
`timescale 1ns/100ps
module link_partner
(
  input wire logic mclk,
  output logic req_dllp
);
  initial req_dllp = 1'b0;
  task automatic send(input int cnt, input int gap);
    repeat (cnt)
    begin
      @(posedge mclk);
      req_dllp <= 1'b1;
      @(posedge mclk);
      req_dllp <= 1'b0;
      repeat (gap) @(posedge mclk);
    end
  endtask
endmodule

// ===== bench/test_l1_aspm_rejection_timer.sv
// Purpose: Self-checking bench for the rejection timer.
// Assumes: Zero-wait APB slave and one-cycle link pulses.
// Notes: Hold lengths are compared with a small margin.
`timescale 1ns/100ps
module test_l1_aspm_rejection_timer
  import rej_timer_pkg::*;
;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  apb_req_t apb_req = '0;
  apb_rsp_t apb_rsp;
  logic req_dllp;
  logic req_detect;
  logic holdoff;
  logic ack_sent = 1'b0;
  logic nak_sent = 1'b0;
  logic [31:0] rd;
  int fail_count = 0;
  int compares = 0;
  int n;
  int t;
  // Case word: spacing, select at bit 16, Nak (not ack) at bit 20.
  logic [31:0] cfg_t [6] = '{32'h0011_0040, 32'h0011_0040, 32'h0010_0040, 32'h0010_0000, 32'h0001_0040,
    32'h0011_3FFF};
  int early_t [6] = '{-1, 4, 4, -1, -1, -1};
  always #12.5 mclk = ~mclk;
  l1_aspm_rejection_timer l1_aspm_rejection_timer_inst (.mclk, .rst, .apb_req, .apb_rsp, .req_dllp,
    .ack_sent, .nak_sent, .req_detect, .holdoff);
  link_partner link_partner_inst (.mclk, .req_dllp);
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      fail_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic complete_run();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic hang();
    fail_count++;
    complete_run();
  endtask
  // One APB transfer, started just after an edge; read data lands in rd.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge mclk);
    apb_req.penable <= 1'b1;
    for (int i = 0; i <= 16; i++)
    begin
      @(posedge mclk);
      if (apb_rsp.pready === 1'b1)
        break;
      if (i == 16)
        hang();
    end
    rd = apb_rsp.prdata;
    apb_req <= '0;
    @(posedge mclk);
  endtask
  // Opens a request, answers it, and counts the hold cycles into n.
  task automatic reject(input logic nak, input int early);
    link_partner_inst.send(1, 0);
    for (int i = 0; i <= 8; i++)
    begin
      @(posedge mclk);
      if (req_detect === 1'b1)
        break;
      if (i == 8)
        hang();
    end
    nak_sent <= nak;
    ack_sent <= !nak;
    @(posedge mclk);
    {nak_sent, ack_sent} <= 2'h0;
    n = 0;
    for (int i = 0; i <= 4000; i++)
    begin
      @(posedge mclk);
      if (i == early)
        fork
          link_partner_inst.send(1, 0);
        join_none
      if (holdoff !== 1'b1)
        break;
      n++;
      if (i == 4000)
        hang();
    end
  endtask
  // Main sequence: reset values, access kinds, then each hold case.
  initial
  begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    apb(1'b0, 12'h710, '0);
    chk("ctrl_reset", 32'h0001_0947, rd);
    apb(1'b1, 12'h710, 32'hFFFF_FFFF);
    apb(1'b0, 12'h710, '0);
    chk("ctrl_rw", 32'h0001_3FFF, rd);
    apb(1'b0, 12'h700, '0);
    chk("unmapped", 32'h0000_0000, rd);
    foreach (cfg_t[k])
    begin
      apb(1'b1, 12'h710, cfg_t[k]);
      reject(cfg_t[k][20], early_t[k]);
      // An early DLLP restarts the count early + 3 cycles after the Nak, which lengthens the hold.
      t = cfg_t[k][13:0] * 4 / 25;
      if (!cfg_t[k][16] && early_t[k] >= 0)
        t = t + early_t[k] + 3;
      if (!cfg_t[k][20] || cfg_t[k][13:0] == 14'h0000)
        chk("hold_none", 32'h0, n);
      else
        chk("hold_len", 32'h1, 32'(n >= t - 1 && n <= t + 4));
    end
    apb(1'b0, 12'h714, '0);
    chk("status_idle", 32'h1, 32'(rd[16] == 1'b0 && rd[14:0] >= 15'h3FFF));
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    apb(1'b0, 12'h710, '0);
    chk("ctrl_rearm", 32'h0001_0947, rd);
    complete_run();
  end
endmodule
